// file: inc/rwc_pkg.sv
// Function
// - Any wake source turns regulator on
// - Enable stays latched after source drops
// - Only off request, supply loss or rst_n clears
// - Sample design-time bits each time supply becomes good
// - Off request high disables regulator unless test reset high
// - Counter match wake is active high
// - Core good and powered show function
// - Test reset high forces regulator on
// - Match wake gated by enable bit
package rwc_pkg;

  // ==========================================================
  // Bus layout
  localparam int RWC_ADDR_W = 4;
  localparam logic [RWC_ADDR_W-1:0] RWC_OFF_CTRL = 4'h0;
  localparam logic [RWC_ADDR_W-1:0] RWC_OFF_STATUS = 4'h4;
  localparam logic [1:0] RWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RWC_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register fields
  localparam int RWC_CTRL_MATCH_EN = 0;
  localparam int RWC_STAT_REG_ON = 0;
  localparam int RWC_STAT_LATCH = 1;
  localparam int RWC_STAT_SUPPLY = 2;
  localparam int RWC_STAT_PIN_WAKE = 3;
  localparam int RWC_STAT_TRST = 4;
  localparam int RWC_STAT_MATCH = 5;
  localparam logic RWC_MATCH_EN_RST = 1'h0;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    RWC_ST_NOSUP = 2'h0,
    RWC_ST_INIT = 2'h1,
    RWC_ST_RUN = 2'h2
  } rwc_state_t;

  typedef struct packed {
    rwc_state_t state;
    logic [2:0] pin_sync;
    logic pin_f;
    logic [2:0] sup_sync;
    logic sup_f;
    logic [2:0] trst_sync;
    logic trst_f;
    logic latch;
    logic match_en;
    logic reg_en_out;
    logic good_out;
    logic pwr_out;
    logic aw_got;
    logic [RWC_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rwc_st_t;

  // Wake pin and supply reset inactive; trst reset high keeps the regulator safe
  localparam rwc_st_t RWC_ST_RST = '{
    state: RWC_ST_NOSUP,
    pin_sync: 3'h7,
    pin_f: 1'h1,
    sup_sync: 3'h0,
    sup_f: 1'h0,
    trst_sync: 3'h7,
    trst_f: 1'h1,
    latch: 1'h0,
    match_en: RWC_MATCH_EN_RST,
    reg_en_out: 1'h1,
    good_out: 1'h0,
    pwr_out: 1'h0,
    aw_got: 1'h0,
    aw_addr: 4'h0,
    w_got: 1'h0,
    w_data: 32'h0,
    w_strb: 4'h0,
    awready: 1'h1,
    wready: 1'h1,
    bvalid: 1'h0,
    bresp: 2'h0,
    arready: 1'h1,
    rvalid: 1'h0,
    rdata: 32'h0,
    rresp: 2'h0
  };

endpackage : rwc_pkg

// file: tb/rwc_fabric_model.sv
`timescale 1ns/1ps
// ==========================================================
// Fabric and counter stand-in
module rwc_fabric_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cnt_run,
  input wire logic [7:0] match_val,
  input wire logic off_cmd,
  output logic match_output,
  output logic regulator_off_request
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      match_output <= 1'h0;
      regulator_off_request <= 1'h0;
    end else begin
      // Counter wraps, so a match recurs every 256 cycles
      cnt_q <= cnt_run ? cnt_q + 8'h01 : 8'h00;
      match_output <= cnt_run && (cnt_q == match_val);
      regulator_off_request <= off_cmd;
    end
  end
endmodule : rwc_fabric_model

// file: tb/rwc_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module rwc_top_tb;
  import rwc_pkg::*;
  logic clk, rst_n, ce, wake_pin_n, supply_good, trst, off_rq, match_o;
  logic init_feature_en, init_state_select, reg_en, core_good, core_pwr;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cnt_run, off_cmd;
  logic [7:0] match_val;
  int error_cnt, comparisons, cyc;
  rwc_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .wake_pin_n(wake_pin_n),
    .supply_good(supply_good), .trst(trst), .regulator_off_request(off_rq),
    .match_output(match_o), .init_feature_en(init_feature_en),
    .init_state_select(init_state_select), .regulator_enable(reg_en),
    .core_good(core_good), .core_powered(core_pwr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rwc_fabric_model fab (.clk(clk), .rst_n(rst_n), .cnt_run(cnt_run),
    .match_val(match_val), .off_cmd(off_cmd), .match_output(match_o),
    .regulator_off_request(off_rq));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end
  task test_done;
    $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Handshakes judged on the rising edge that completes them
  task wr(input logic [3:0] a, input logic [31:0] v);
    logic tb;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        tb = 1'h1;
        r = bresp;
        bready <= 1'h0;
      end
    end
  endtask : wr
  task rd(input logic [3:0] a);
    logic tr;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        tr = 1'h1;
        d = rdata;
        r = rresp;
        rready <= 1'h0;
      end
    end
  endtask : rd
  task off_pulse;
    off_cmd <= 1'h1;
    wt(3);
    off_cmd <= 1'h0;
    wt(3);
  endtask : off_pulse
  task t_init;
    chk("rst reg_en", 1, reg_en);
    chk("rst good", 0, core_good);
    trst <= 1'h0;
    supply_good <= 1'h1;
    init_feature_en <= 1'h1;
    wt(10);
    chk("init off", 0, reg_en);
    rd(RWC_OFF_STATUS);
    chk("status", 32'h4, d);
  endtask : t_init
  task t_pin;
    wake_pin_n <= 1'h0;
    wt(6);
    wake_pin_n <= 1'h1;
    wt(6);
    chk("pin latch", 1, reg_en);
    chk("good", 1, core_good);
    chk("powered", 1, core_pwr);
    off_pulse;
    chk("off", 0, reg_en);
  endtask : t_pin
  task t_match;
    match_val <= 8'h05;
    cnt_run <= 1'h1;
    wt(300);
    chk("gated", 0, reg_en);
    wr(RWC_OFF_CTRL, 32'h1);
    chk("wr resp", RWC_RESP_OKAY, r);
    rd(RWC_OFF_CTRL);
    chk("ctrl", 32'h1, d);
    wt(300);
    chk("match on", 1, reg_en);
    cnt_run <= 1'h0;
    rd(4'h8);
    chk("unmapped", RWC_RESP_SLVERR, r);
  endtask : t_match
  task t_supply;
    supply_good <= 1'h0;
    wt(6);
    chk("loss en", 0, reg_en);
    chk("loss good", 0, core_good);
    init_state_select <= 1'h1;
    supply_good <= 1'h1;
    wt(10);
    chk("init on", 1, reg_en);
  endtask : t_supply
  task t_trst;
    off_pulse;
    trst <= 1'h1;
    wt(6);
    chk("trst force", 1, reg_en);
    chk("trst good", 0, core_good);
  endtask : t_trst
  // Frozen clock enable must hold off a pending pin wake
  task t_ce;
    trst <= 1'h0;
    wt(6);
    chk("trst low", 0, reg_en);
    ce <= 1'h0;
    wake_pin_n <= 1'h0;
    wt(8);
    chk("frozen", 0, reg_en);
    ce <= 1'h1;
    wt(8);
    chk("thawed", 1, reg_en);
    wake_pin_n <= 1'h1;
  endtask : t_ce
  task t_init_off;
    init_feature_en <= 1'h0;
    supply_good <= 1'h0;
    wt(8);
    chk("loss pwr", 0, core_pwr);
    supply_good <= 1'h1;
    wt(12);
    chk("init unused", 0, reg_en);
    wr(RWC_OFF_STATUS, 32'h0);
    chk("ro write", RWC_RESP_OKAY, r);
    rd(RWC_OFF_CTRL);
    chk("ctrl kept", 32'h1, d);
  endtask : t_init_off
  initial begin
    {error_cnt, comparisons, cyc} = '0;
    {rst_n, supply_good, off_cmd, cnt_run, init_feature_en} = '0;
    {init_state_select, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata, match_val} = '0;
    ce = 1'h1;
    trst = 1'h1;
    wake_pin_n = 1'h1;
    wt(4);
    rst_n <= 1'h1;
    wt(1);
    t_init;
    t_pin;
    t_match;
    t_supply;
    t_trst;
    t_ce;
    t_init_off;
    test_done;
  end
endmodule : rwc_top_tb

// file: verilog/rwc_top.sv
`timescale 1ns/1ps
module rwc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wake_pin_n,
  input wire logic supply_good,
  input wire logic trst,
  input wire logic regulator_off_request,
  input wire logic match_output,
  input wire logic init_feature_en,
  input wire logic init_state_select,
  output logic regulator_enable,
  output logic core_good,
  output logic core_powered,
  input wire logic [rwc_pkg::RWC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rwc_pkg::RWC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rwc_pkg::*;

  rwc_st_t st_q;
  rwc_st_t st_d;
  logic counter_match_wake;
  logic wake_any;

  // ==========================================================
  // Helpers
  // Only stages two and three are looked at; stage one may be metastable
  function automatic logic rwc_filt(input logic [2:0] s, input logic f);
    rwc_filt = (s[1] == s[2]) ? s[2] : f;
  endfunction : rwc_filt

  function automatic logic [RWC_ADDR_W-1:0] rwc_word(
    input logic [RWC_ADDR_W-1:0] a);
    rwc_word = {a[RWC_ADDR_W-1:2], 2'h0};
  endfunction : rwc_word

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.pin_sync = {st_q.pin_sync[1:0], wake_pin_n};
    st_d.pin_f = rwc_filt(st_q.pin_sync, st_q.pin_f);
    st_d.sup_sync = {st_q.sup_sync[1:0], supply_good};
    st_d.sup_f = rwc_filt(st_q.sup_sync, st_q.sup_f);
    st_d.trst_sync = {st_q.trst_sync[1:0], trst};
    st_d.trst_f = rwc_filt(st_q.trst_sync, st_q.trst_f);
    counter_match_wake = match_output & st_q.match_en;
    wake_any = ~st_q.pin_f | counter_match_wake;

    case (st_q.state)
      RWC_ST_NOSUP: begin
        st_d.latch = 1'h0;
        if (st_q.sup_f) begin
          st_d.state = RWC_ST_INIT;
        end
      end
      RWC_ST_INIT: begin
        if (!st_q.sup_f) begin
          st_d.latch = 1'h0;
          st_d.state = RWC_ST_NOSUP;
        end else begin
          st_d.latch = init_feature_en & init_state_select;
          st_d.state = RWC_ST_RUN;
        end
      end
      RWC_ST_RUN: begin
        if (!st_q.sup_f) begin
          st_d.latch = 1'h0;
          st_d.state = RWC_ST_NOSUP;
        end else if (regulator_off_request) begin
          st_d.latch = 1'h0;
        end else if (wake_any) begin
          st_d.latch = 1'h1;
        end
      end
      default: begin
        st_d.latch = 1'h0;
        st_d.state = RWC_ST_NOSUP;
      end
    endcase

    st_d.reg_en_out = st_d.latch | st_d.trst_f;
    st_d.good_out = st_d.latch & st_d.sup_f;
    st_d.pwr_out = st_d.latch & st_d.sup_f;

    // ========================================================
    // AXI4-Lite write
    if (st_q.awready && s_axi_awvalid) begin
      st_d.aw_got = 1'h1;
      st_d.aw_addr = s_axi_awaddr;
      st_d.awready = 1'h0;
    end
    if (st_q.wready && s_axi_wvalid) begin
      st_d.w_got = 1'h1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
      st_d.wready = 1'h0;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.aw_got = 1'h0;
      st_d.w_got = 1'h0;
      st_d.bvalid = 1'h1;
      if (rwc_word(st_q.aw_addr) == RWC_OFF_CTRL) begin
        st_d.bresp = RWC_RESP_OKAY;
        if (st_q.w_strb[0]) begin
          st_d.match_en = st_q.w_data[RWC_CTRL_MATCH_EN];
        end
      end else if (rwc_word(st_q.aw_addr) == RWC_OFF_STATUS) begin
        // Status is read only; writes are accepted and dropped
        st_d.bresp = RWC_RESP_OKAY;
      end else begin
        st_d.bresp = RWC_RESP_SLVERR;
      end
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'h0;
      st_d.awready = 1'h1;
      st_d.wready = 1'h1;
    end

    // ========================================================
    // AXI4-Lite read
    if (st_q.arready && s_axi_arvalid) begin
      st_d.arready = 1'h0;
      st_d.rvalid = 1'h1;
      st_d.rdata = 32'h0;
      st_d.rresp = RWC_RESP_OKAY;
      if (rwc_word(s_axi_araddr) == RWC_OFF_CTRL) begin
        st_d.rdata[RWC_CTRL_MATCH_EN] = st_q.match_en;
      end else if (rwc_word(s_axi_araddr) == RWC_OFF_STATUS) begin
        st_d.rdata[RWC_STAT_REG_ON] = st_q.reg_en_out;
        st_d.rdata[RWC_STAT_LATCH] = st_q.latch;
        st_d.rdata[RWC_STAT_SUPPLY] = st_q.sup_f;
        st_d.rdata[RWC_STAT_PIN_WAKE] = ~st_q.pin_f;
        st_d.rdata[RWC_STAT_TRST] = st_q.trst_f;
        st_d.rdata[RWC_STAT_MATCH] = counter_match_wake;
      end else begin
        st_d.rresp = RWC_RESP_SLVERR;
      end
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'h0;
      st_d.arready = 1'h1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= RWC_ST_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign regulator_enable = st_q.reg_en_out;
  assign core_good = st_q.good_out;
  assign core_powered = st_q.pwr_out;
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pin_wake_on:
    assert property (ce && st_q.state == RWC_ST_RUN && st_q.sup_f &&
      !st_q.pin_f && !regulator_off_request |=> st_q.latch)
    else $error("wake pin low did not set enable");

  a_match_wake_on:
    assert property (ce && st_q.state == RWC_ST_RUN && st_q.sup_f &&
      match_output && st_q.match_en && !regulator_off_request
      |=> st_q.latch && regulator_enable)
    else $error("enabled match did not set enable");

  a_match_gated:
    assert property (ce && st_q.state == RWC_ST_RUN && !st_q.latch &&
      st_q.pin_f && !st_q.match_en |=> !st_q.latch)
    else $error("enable set with no active wake source");

  a_latch_holds:
    assert property (ce && st_q.latch && st_q.sup_f &&
      st_q.state == RWC_ST_RUN && !regulator_off_request |=> st_q.latch)
    else $error("enable dropped without a cause");

  a_off_request:
    assert property (ce && st_q.state == RWC_ST_RUN && st_q.sup_f &&
      regulator_off_request && !st_q.trst_f && !st_d.trst_f
      |=> !st_q.latch && !regulator_enable && !core_good)
    else $error("off request did not disable regulator");

  a_supply_clear:
    assert property (ce && !st_q.sup_f
      |=> !st_q.latch && st_q.state == RWC_ST_NOSUP && !core_powered)
    else $error("supply loss did not clear enable");

  a_init_sample:
    assert property (ce && st_q.state == RWC_ST_INIT && st_q.sup_f
      |=> st_q.state == RWC_ST_RUN &&
      st_q.latch == $past(init_feature_en && init_state_select))
    else $error("init bits not sampled on reset exit");

  a_good_outputs:
    assert property (core_good == core_powered &&
      (!core_good || (regulator_enable && st_q.sup_f)))
    else $error("core status outputs disagree");

  a_trst_force:
    assert property (st_q.trst_f |-> regulator_enable)
    else $error("test reset high did not force regulator on");

  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule : rwc_top
